//--- dv/fel_contact_model.sv
// Far-side model: bouncing reset contact, control supply, bus option
// Assumes the bench requests contact and supply levels on core_clk
`timescale 1ns/10ps
`default_nettype none
module fel_contact_model (
  input wire logic core_clk,
  input wire logic close_req,
  input wire logic supply_req,
  input wire logic fieldbus_reset,
  output var logic reset_closed,
  output var logic supply_ok,
  output var int bus_resets
);
  logic last_req;
  logic fb_q;
  int bounce;
  initial begin
    reset_closed = 1'b0;
    supply_ok = 1'b0;
    last_req = 1'b0;
    fb_q = 1'b0;
    bounce = 0;
    bus_resets = 0;
  end
  // Contact chatters for a few cycles before it settles
  always @(posedge core_clk) begin
    supply_ok <= supply_req;
    if (close_req != last_req) begin
      last_req <= close_req;
      bounce <= 4;
      reset_closed <= close_req;
    end else if (bounce > 0) begin
      bounce <= bounce - 1;
      reset_closed <= (bounce == 1) ? last_req : ~reset_closed;
    end
  end
  // Bus option counts each reset it receives
  always @(posedge core_clk) begin
    fb_q <= fieldbus_reset;
    if (fieldbus_reset && !fb_q) begin
      bus_resets <= bus_resets + 1;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the event log and reset block
// Assumes short debounce and one-shot counts set at the instance
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fel_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, reset_closed, supply_ok, trig_enable, comm_enable;
  logic reinit_busy, led_on_red, fieldbus_reset, nvm_commit;
  logic first_signal_relay, second_signal_relay, third_signal_relay;
  logic close_req = 1'b1, supply_req = 1'b1, lock_in = 1'b0;
  logic [31:0] evt_src = 32'h0;
  logic [15:0] evt_value = 16'h1234;
  logic [31:0] rtc_date = 32'h20000102;
  logic [23:0] rtc_time = 24'h123456;
  int bus_resets, errors = 0, n_tests = 0;
  int n_commit = 0;
  logic [31:0] q;

  // Count log commit pulses
  always @(posedge core_clk) begin
    if (nvm_commit === 1'b1) begin
      n_commit <= n_commit + 1;
    end
  end

  fel_top #(.DEB_CYC(4), .MONO_CYC(8)) DUT (.core_clk(core_clk),
    .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .reset_closed(reset_closed),
    .supply_ok(supply_ok), .lock_in(lock_in), .evt_src(evt_src),
    .evt_value(evt_value), .rtc_date(rtc_date), .rtc_time(rtc_time),
    .trig_enable(trig_enable), .comm_enable(comm_enable),
    .reinit_busy(reinit_busy), .led_on_red(led_on_red),
    .fieldbus_reset(fieldbus_reset),
    .first_signal_relay(first_signal_relay),
    .second_signal_relay(second_signal_relay),
    .third_signal_relay(third_signal_relay), .nvm_commit(nvm_commit));
  fel_contact_model partner (.core_clk(core_clk), .close_req(close_req),
    .supply_req(supply_req), .fieldbus_reset(fieldbus_reset),
    .reset_closed(reset_closed), .supply_ok(supply_ok),
    .bus_resets(bus_resets));

  // Free-running core clock
  always #12.5 core_clk = ~core_clk;

  task final_report();
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    if (i >= 50) begin
      errors++;
      final_report();
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Bounded wait for one output to reach a level
  task wait_sig(input int s, input logic v, input int lim);
    logic x;
    for (int i = 0; i < lim; i++) begin
      @(posedge core_clk);
      case (s)
        0: x = comm_enable;
        1: x = led_on_red;
        2: x = reinit_busy;
        3: x = first_signal_relay;
        4: x = second_signal_relay;
        5: x = third_signal_relay;
        default: x = trig_enable;
      endcase
      if (x === v) return;
    end
    errors++;
    final_report();
  endtask

  task t_power_up();
    chk({31'h0, led_on_red}, 32'h1);
    wait_sig(0, 1'b1, 3000);
    wait_sig(5, 1'b1, 20);
    wait_sig(5, 1'b0, 20);
    wb_xfer(1'b0, OFS_LOG_INFO, 32'h0);
    chk(q & 32'h00030f1f, 32'h00020101);
    wb_xfer(1'b1, OFS_LOG_SEL, 32'h0);
    wb_xfer(1'b0, OFS_ENT_EVV, 32'h0);
    chk(q, 32'h00131234);
    wb_xfer(1'b0, OFS_ENT_DATE, 32'h0);
    chk(q, rtc_date);
    wb_xfer(1'b0, OFS_ENT_TIME, 32'h0);
    chk(q & 32'h00ffffff, {8'h00, rtc_time});
  endtask
  task t_defaults();
    wb_xfer(1'b0, OFS_LOG_MASK, 32'h0);
    chk(q, 32'h00080000);
    wb_xfer(1'b0, OFS_RLY1, 32'h0);
    chk(q, 32'h01000000);
    wb_xfer(1'b0, OFS_RLY2, 32'h0);
    chk(q, 32'h00000800);
    wb_xfer(1'b0, OFS_RLY3, 32'h0);
    chk(q, 32'h00000080);
    wb_xfer(1'b1, 8'h40, 32'hffffffff);
    wb_xfer(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
  endtask
  task t_wrap();
    wb_xfer(1'b1, OFS_LOG_MASK, 32'h00081000);
    for (int i = 0; i < 17; i++) begin
      @(posedge core_clk);
      evt_src <= 32'h00001000;
      evt_value <= 16'(i);
      @(posedge core_clk);
      evt_src <= 32'h0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    wb_xfer(1'b0, OFS_LOG_INFO, 32'h0);
    chk(q & 32'h00030f1f, 32'h00020210);
    chk(32'(n_commit), 32'h12);
    wb_xfer(1'b1, OFS_LOG_SEL, 32'h1);
    wb_xfer(1'b0, OFS_ENT_EVV, 32'h0);
    chk(q, 32'h000c0010);
    wb_xfer(1'b1, OFS_LOG_SEL, 32'h2);
    wb_xfer(1'b0, OFS_ENT_EVV, 32'h0);
    chk(q, 32'h000c0001);
  endtask
  task t_relays();
    wb_xfer(1'b1, OFS_RLY1, 32'h02000000);
    evt_src <= 32'h00001000;
    wait_sig(3, 1'b1, 20);
    chk({30'h0, first_signal_relay, second_signal_relay}, 32'h2);
    evt_src <= 32'h00000800;
    wait_sig(4, 1'b1, 20);
    wait_sig(3, 1'b0, 20);
    chk({30'h0, first_signal_relay, second_signal_relay}, 32'h1);
    evt_src <= 32'h0;
    lock_in <= 1'b1;
    wait_sig(6, 1'b0, 20);
    wb_xfer(1'b0, OFS_STATUS, 32'h0);
    chk({30'h0, q[8], comm_enable}, 32'h3);
    lock_in <= 1'b0;
    wait_sig(6, 1'b1, 20);
    evt_src <= 32'h40030000;
    wb_xfer(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h40030000, 32'h0);
    wb_xfer(1'b1, OFS_CTRL, 32'h0000001e);
    wb_xfer(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h42030000, 32'h42030000);
    evt_src <= 32'h0;
  endtask
  task t_contact();
    wb_xfer(1'b1, OFS_CTRL, 32'h00000010);
    close_req <= 1'b0;
    wait_sig(1, 1'b1, 50);
    chk({trig_enable, comm_enable, fieldbus_reset}, 32'h1);
    @(posedge core_clk);
    chk(32'(bus_resets), 32'h1);
    close_req <= 1'b1;
    wait_sig(2, 1'b1, 50);
    wait_sig(0, 1'b1, 3000);
    wb_xfer(1'b1, OFS_CTRL, 32'h00000011);
    wait_sig(2, 1'b1, 20);
    chk({31'h0, fieldbus_reset}, 32'h0);
    wait_sig(0, 1'b1, 3000);
    chk(32'(bus_resets), 32'h1);
    supply_req <= 1'b0;
    wait_sig(1, 1'b1, 20);
    chk({comm_enable, fieldbus_reset}, 32'h1);
    supply_req <= 1'b1;
    wait_sig(0, 1'b1, 3000);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_power_up();
    t_defaults();
    t_wrap();
    t_relays();
    t_contact();
    final_report();
  end
endmodule
`default_nettype wire

//--- verilog/fel_log_if.sv
// Link between the event controller and the fault log store
// Assumes both ends run on the same core clock
`timescale 1ns/10ps
`default_nettype none
interface fel_log_if;
  import fel_pkg::*;
  logic wr_stb;
  fel_entry_t wr_entry;
  logic [IDX_W-1:0] rd_idx;
  fel_entry_t rd_entry;
  logic [IDX_W-1:0] wr_idx;
  logic [CNT_W-1:0] count;
  modport ctl (output wr_stb, wr_entry, rd_idx,
    input rd_entry, wr_idx, count);
  modport mem (input wr_stb, wr_entry, rd_idx,
    output rd_entry, wr_idx, count);
endinterface
`default_nettype wire

//--- verilog/fel_log_mem.sv
// Sixteen-entry fault log with oldest-entry overwrite
// Assumes the entry array is mapped onto retained storage
`timescale 1ns/10ps
`default_nettype none
module fel_log_mem
  import fel_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  fel_log_if.mem log
);

  fel_entry_t mem_q [LOG_DEPTH];
  logic [IDX_W-1:0] idx_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic full;

  assign full = (cnt_reg == CNT_W'(LOG_DEPTH));
  assign log.rd_entry = mem_q[log.rd_idx];
  assign log.wr_idx = idx_reg;
  assign log.count = cnt_reg;

  // Entry store, no reset so contents are retained
  always_ff @(posedge core_clk) begin
    if (log.wr_stb) begin
      mem_q[idx_reg] <= log.wr_entry;
    end
  end

  // Wrapping write index and saturating count
  always_ff @(posedge core_clk) begin
    if (srst) begin
      idx_reg <= '0;
      cnt_reg <= '0;
    end else if (log.wr_stb) begin
      idx_reg <= idx_reg + 4'h1;
      cnt_reg <= full ? cnt_reg : cnt_reg + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_count_bound: assert property (cnt_reg <= CNT_W'(LOG_DEPTH))
    else $error("log count above depth");
  a_index_wrap: assert property (
    log.wr_stb && idx_reg == 4'hf |=> idx_reg == 4'h0)
    else $error("write index did not wrap");
  a_count_grow: assert property (
    log.wr_stb && !full |=> cnt_reg == $past(cnt_reg) + 5'h01)
    else $error("count did not grow");
  c_log_wrap: cover property (log.wr_stb && full && idx_reg == 4'hf);

endmodule
`default_nettype wire

//--- verilog/fel_pkg.sv
// Constants, types and helpers for the fault event log and reset block
// Assumes a single 40 MHz core clock and a classic Wishbone register bus
package fel_pkg;

  // Clock rate and timing figures
  localparam int CLK_MHZ = 40;
  localparam int DEB_TIME_US = 1000;
  localparam int DEB_CYC_DEF = DEB_TIME_US * CLK_MHZ;
  localparam int REINIT_TIME_US = 50;
  localparam int REINIT_CYC = REINIT_TIME_US * CLK_MHZ;
  localparam int MONO_TIME_MS = 100;
  localparam int MONO_CYC_DEF = MONO_TIME_MS * 1000 * CLK_MHZ;

  // Log geometry
  localparam int LOG_DEPTH = 16;
  localparam int IDX_W = 4;
  localparam int CNT_W = 5;

  // Event numbers
  localparam int EV_SERIAL = 1;
  localparam int EV_OPTICAL = 2;
  localparam int EV_NEG_PWR = 3;
  localparam int EV_COMM_FLT = 4;
  localparam int EV_SYNC_IF = 5;
  localparam int EV_EXT_PORT = 6;
  localparam int EV_AFTER_RST = 7;
  localparam int EV_LOCK = 8;
  localparam int EV_PARAM_BAD = 9;
  localparam int EV_UNDER_CUR = 16;
  localparam int EV_OVER_CUR = 17;
  localparam int EV_SUPPLY_BACK = 19;
  localparam int EV_COLLECT = 25;
  localparam int EV_PEAK = 30;

  // Event groups
  localparam logic [31:0] OWN_MASK = 32'h420b0181;
  localparam logic [31:0] FAULT_MASK = 32'h8133b270;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LOG_MASK = 8'h08;
  localparam logic [7:0] OFS_RLY1 = 8'h0c;
  localparam logic [7:0] OFS_RLY2 = 8'h10;
  localparam logic [7:0] OFS_RLY3 = 8'h14;
  localparam logic [7:0] OFS_LOG_INFO = 8'h18;
  localparam logic [7:0] OFS_LOG_SEL = 8'h1c;
  localparam logic [7:0] OFS_ENT_DATE = 8'h20;
  localparam logic [7:0] OFS_ENT_TIME = 8'h24;
  localparam logic [7:0] OFS_ENT_EVV = 8'h28;

  // Control fields
  localparam int CTRL_SOFT_RST = 0;
  localparam int CTRL_UC_EN = 1;
  localparam int CTRL_OC_EN = 2;
  localparam int CTRL_PEAK_MODE = 3;
  localparam int CTRL_BUS_FIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CTRL_RD_MASK = 32'h0000001e;

  // Routing reset values
  localparam logic [31:0] LOG_MASK_RST = 32'h00080000;
  localparam logic [31:0] RLY1_RST = 32'h01000000;
  localparam logic [31:0] RLY2_RST = 32'h00000800;
  localparam logic [31:0] RLY3_RST = 32'h00000080;

  // Log info fields
  localparam int INFO_IDX_LSB = 8;
  localparam int INFO_IN_RST = 16;
  localparam int INFO_RUN = 17;

  // One log entry: BCD date, BCD time, event number, value
  typedef struct packed {
    logic [31:0] date;
    logic [23:0] tod;
    logic [4:0] evt;
    logic [15:0] value;
  } fel_entry_t;

  // Lowest set bit of an event vector
  function automatic logic [4:0] fel_first(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] fel_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

//--- verilog/fel_top.sv
// Event routing, fault logging and hardware reset control
// Assumes Wishbone master, raw pins for reset contact, supply, lock
//
// Function
// - Log holds no more than 16 entries
// - Full log overwrites its oldest entry
// - Entry holds date, time, event, value
// - Log contents survive supply loss
// - Events 1 to 6: links and interfaces
// - Events 12-17; 16, 17 need enables
// - Events 20, 21 voltage; 31 sensor fault
// - Event 8 lock; event 9 bad parameters
// - Event 7 one-shot after reset, third relay
// - Per-event log and relay routing, defaults
// - Event 25 whenever any fault active
// - Event 30 on peak limit, peak mode
// - Event 19 once on supply return
// - Open reset contact blocks trigger pulses
// - Reset halts comms; reinit then enable
// - Power indicator red during reset
// - Hardware reset forwarded to fitted bus
// - Supply loss also trips hardware reset
// - Software reset leaves fieldbus untouched
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module fel_top
  import fel_pkg::*;
#(
  parameter int DEB_CYC = DEB_CYC_DEF,
  parameter int MONO_CYC = MONO_CYC_DEF
)(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_closed,
  input wire logic supply_ok,
  input wire logic lock_in,
  input wire logic [31:0] evt_src,
  input wire logic [15:0] evt_value,
  input wire logic [31:0] rtc_date,
  input wire logic [23:0] rtc_time,
  output logic trig_enable,
  output logic comm_enable,
  output logic reinit_busy,
  output logic led_on_red,
  output logic fieldbus_reset,
  output logic first_signal_relay,
  output logic second_signal_relay,
  output logic third_signal_relay,
  output logic nvm_commit
);

  typedef enum logic [1:0] {ST_RESET, ST_REINIT, ST_RUN} fel_state_t;

  localparam int PIN_RST = 0;
  localparam int PIN_SUP = 1;
  localparam int PIN_LOCK = 2;

  fel_log_if log_if ();

  logic [2:0] pins, sync1_reg, sync2_reg;
  logic closed_db_reg, sup_s, lock_s, sup_prev_reg, hw_rst;
  logic [31:0] deb_cnt_reg, tmr_reg, mono_reg;
  fel_state_t state_reg, state_next;
  logic reinit_done, soft_req_reg;
  logic [31:0] ctrl_reg, log_mask_reg, rly1_reg, rly2_reg, rly3_reg;
  logic [IDX_W-1:0] sel_reg;
  logic [31:0] ev_fix, ev_gated, ev_vec, ev_prev_reg, rise, pend_reg;
  logic [31:0] pick_oh, rd_mux, info;
  logic [4:0] pick;
  logic pick_ok, any_fault, req, wr_en;

  // Pin synchronisers, two flops each
  assign pins = {lock_in, supply_ok, reset_closed};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (srst) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
      end else begin
        sync1_reg[g] <= pins[g];
        sync2_reg[g] <= sync1_reg[g];
      end
    end
  end
  assign sup_s = sync2_reg[PIN_SUP];
  assign lock_s = sync2_reg[PIN_LOCK];

  // Reset contact debounce: level must hold DEB_CYC cycles
  always_ff @(posedge core_clk) begin
    if (srst) begin
      closed_db_reg <= 1'b0;
      deb_cnt_reg <= '0;
    end else if (sync2_reg[PIN_RST] == closed_db_reg) begin
      deb_cnt_reg <= '0;
    end else if (deb_cnt_reg == 32'(DEB_CYC - 1)) begin
      closed_db_reg <= sync2_reg[PIN_RST];
      deb_cnt_reg <= '0;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 32'h1;
    end
  end

  // Hardware reset from contact or supply loss
  assign hw_rst = !closed_db_reg || !sup_s;
  assign reinit_done = (tmr_reg == 32'(REINIT_CYC - 1));

  // Reset sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET: begin
        if (!hw_rst) begin
          state_next = ST_REINIT;
        end
      end
      ST_REINIT: begin
        if (hw_rst) begin
          state_next = ST_RESET;
        end else if (reinit_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hw_rst) begin
          state_next = ST_RESET;
        end else if (soft_req_reg) begin
          state_next = ST_REINIT;
        end
      end
    endcase
  end

  // State, reinit timer and after-reset monoflop
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_RESET;
      tmr_reg <= '0;
      mono_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= (state_reg == ST_REINIT) ? tmr_reg + 32'h1 : '0;
      if (state_reg == ST_REINIT && state_next == ST_RUN) begin
        mono_reg <= 32'(MONO_CYC);
      end else if (mono_reg != '0) begin
        mono_reg <= mono_reg - 32'h1;
      end
    end
  end

  // Power-section and status outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_enable <= 1'b0;
      comm_enable <= 1'b0;
      reinit_busy <= 1'b0;
      led_on_red <= 1'b1;
      fieldbus_reset <= 1'b0;
    end else begin
      trig_enable <= state_next == ST_RUN && !lock_s;
      comm_enable <= state_next == ST_RUN;
      reinit_busy <= state_next == ST_REINIT;
      led_on_red <= state_next == ST_RESET;
      fieldbus_reset <= hw_rst && ctrl_reg[CTRL_BUS_FIT];
    end
  end

  // Event vector assembly
  assign ev_fix = evt_src & ~OWN_MASK;
  assign ev_gated = ev_fix
    | ({31'h0, evt_src[EV_UNDER_CUR] && ctrl_reg[CTRL_UC_EN]}
       << EV_UNDER_CUR)
    | ({31'h0, evt_src[EV_OVER_CUR] && ctrl_reg[CTRL_OC_EN]}
       << EV_OVER_CUR)
    | ({31'h0, evt_src[EV_PEAK] && ctrl_reg[CTRL_PEAK_MODE]}
       << EV_PEAK)
    | ({31'h0, lock_s} << EV_LOCK)
    | ({31'h0, mono_reg != '0} << EV_AFTER_RST)
    | ({31'h0, sup_s && !sup_prev_reg} << EV_SUPPLY_BACK);
  assign any_fault = |(ev_gated & FAULT_MASK);
  assign ev_vec = ev_gated | ({31'h0, any_fault} << EV_COLLECT);
  assign rise = ev_vec & ~ev_prev_reg;

  // Log selection: lowest pending event first
  assign pick_ok = |pend_reg;
  assign pick = fel_first(pend_reg);
  assign pick_oh = pick_ok ? (32'h1 << pick) : '0;
  assign log_if.wr_stb = pick_ok;
  assign log_if.wr_entry = '{date: rtc_date, tod: rtc_time,
    evt: pick, value: evt_value};
  assign log_if.rd_idx = sel_reg;

  // Edge history and pending log requests, new edge wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ev_prev_reg <= '0;
      pend_reg <= '0;
      sup_prev_reg <= 1'b0;
      nvm_commit <= 1'b0;
    end else begin
      ev_prev_reg <= ev_vec;
      pend_reg <= (pend_reg & ~pick_oh) | (rise & log_mask_reg);
      sup_prev_reg <= sup_s;
      nvm_commit <= pick_ok;
    end
  end

  // Signalling relays
  always_ff @(posedge core_clk) begin
    if (srst) begin
      first_signal_relay <= 1'b0;
      second_signal_relay <= 1'b0;
      third_signal_relay <= 1'b0;
    end else begin
      first_signal_relay <= |(ev_vec & rly1_reg);
      second_signal_relay <= |(ev_vec & rly2_reg);
      third_signal_relay <= |(ev_vec & rly3_reg);
    end
  end

  fel_log_mem u_mem (
    .core_clk(core_clk),
    .srst(srst),
    .log(log_if.mem)
  );

  // Bus decode and read selection
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && wb_ack_o;
  assign info = (32'(log_if.count))
    | (32'(log_if.wr_idx) << INFO_IDX_LSB)
    | ({31'h0, state_reg == ST_RESET} << INFO_IN_RST)
    | ({31'h0, state_reg == ST_RUN} << INFO_RUN);
  assign rd_mux =
    (wb_adr_i == OFS_CTRL) ? (ctrl_reg & CTRL_RD_MASK) :
    (wb_adr_i == OFS_STATUS) ? ev_vec :
    (wb_adr_i == OFS_LOG_MASK) ? log_mask_reg :
    (wb_adr_i == OFS_RLY1) ? rly1_reg :
    (wb_adr_i == OFS_RLY2) ? rly2_reg :
    (wb_adr_i == OFS_RLY3) ? rly3_reg :
    (wb_adr_i == OFS_LOG_INFO) ? info :
    (wb_adr_i == OFS_LOG_SEL) ? 32'(sel_reg) :
    (wb_adr_i == OFS_ENT_DATE) ? log_if.rd_entry.date :
    (wb_adr_i == OFS_ENT_TIME) ? 32'(log_if.rd_entry.tod) :
    (wb_adr_i == OFS_ENT_EVV) ? {11'h000, log_if.rd_entry.evt,
      log_if.rd_entry.value} :
    32'h00000000;

  // Bus answer, one wait cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= (req && !wb_ack_o && !wb_we_i) ? rd_mux : '0;
    end
  end

  // Register writes at the acknowledged edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RST;
      log_mask_reg <= LOG_MASK_RST;
      rly1_reg <= RLY1_RST;
      rly2_reg <= RLY2_RST;
      rly3_reg <= RLY3_RST;
      sel_reg <= '0;
      soft_req_reg <= 1'b0;
    end else begin
      soft_req_reg <= wr_en && wb_adr_i == OFS_CTRL && wb_sel_i[0]
        && wb_dat_i[CTRL_SOFT_RST];
      if (wr_en && wb_adr_i == OFS_CTRL) begin
        ctrl_reg <= fel_merge(ctrl_reg, wb_dat_i, wb_sel_i)
          & CTRL_RD_MASK;
      end
      if (wr_en && wb_adr_i == OFS_LOG_MASK) begin
        log_mask_reg <= fel_merge(log_mask_reg, wb_dat_i, wb_sel_i);
      end
      if (wr_en && wb_adr_i == OFS_RLY1) begin
        rly1_reg <= fel_merge(rly1_reg, wb_dat_i, wb_sel_i);
      end
      if (wr_en && wb_adr_i == OFS_RLY2) begin
        rly2_reg <= fel_merge(rly2_reg, wb_dat_i, wb_sel_i);
      end
      if (wr_en && wb_adr_i == OFS_RLY3) begin
        rly3_reg <= fel_merge(rly3_reg, wb_dat_i, wb_sel_i);
      end
      if (wr_en && wb_adr_i == OFS_LOG_SEL && wb_sel_i[0]) begin
        sel_reg <= wb_dat_i[IDX_W-1:0];
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_trig_blocked: assert property (hw_rst |=> !trig_enable)
    else $error("trigger enabled during reset");
  a_comm_halted: assert property (hw_rst |=> !comm_enable)
    else $error("comms enabled during reset");
  a_reinit_time: assert property (
    state_reg == ST_REINIT ##1 state_reg == ST_RUN
    |-> $past(tmr_reg) == 32'(REINIT_CYC - 1))
    else $error("reinit too short");
  a_led_red: assert property (hw_rst |=> led_on_red)
    else $error("indicator not red in reset");
  a_bus_reset: assert property (
    hw_rst && ctrl_reg[CTRL_BUS_FIT] |=> fieldbus_reset)
    else $error("bus reset missing");
  a_soft_nobus: assert property (!hw_rst |=> !fieldbus_reset)
    else $error("bus reset without hardware reset");
  a_supply_trip: assert property (
    !sup_s |=> state_reg == ST_RESET)
    else $error("supply loss did not reset");
  a_deb_hold: assert property (
    $changed(closed_db_reg) |-> $past(deb_cnt_reg) == 32'(DEB_CYC - 1))
    else $error("debounce too short");
  a_after_rst: assert property (
    state_reg == ST_REINIT && state_next == ST_RUN
    |=> ev_vec[EV_AFTER_RST] ##1 ev_vec[EV_AFTER_RST])
    else $error("after-reset event missing");
  a_collect: assert property (
    |(evt_src & FAULT_MASK & ~OWN_MASK) |-> ev_vec[EV_COLLECT])
    else $error("collective fault missing");
  a_peak_gate: assert property (
    !ctrl_reg[CTRL_PEAK_MODE] |-> !ev_vec[EV_PEAK])
    else $error("peak event outside peak mode");
  a_mon_gate: assert property (
    !ctrl_reg[CTRL_UC_EN] |-> !ev_vec[EV_UNDER_CUR])
    else $error("undercurrent event while disabled");
  a_supply_back: assert property (
    $rose(sup_s) |-> ev_vec[EV_SUPPLY_BACK] ##1 !ev_vec[EV_SUPPLY_BACK])
    else $error("supply return event not one-shot");
  a_lock_event: assert property (
    !$past(srst) && !$past(srst, 2) && $past(lock_in, 2)
    |-> ev_vec[EV_LOCK])
    else $error("lock event missing");
  a_relay_route: assert property (
    |(ev_vec & rly3_reg) |=> third_signal_relay)
    else $error("third relay not driven");
  a_log_entry: assert property (
    pick_ok |=> !pend_reg[$past(pick)]
      || $past(rise[pick] && log_mask_reg[pick]))
    else $error("logged event not retired");

  c_reset_run: cover property ($fell(reinit_busy) && comm_enable);
  c_soft_reset: cover property (soft_req_reg && state_reg == ST_RUN);
  c_two_logs: cover property (pick_ok ##1 pick_ok);
  c_relay1: cover property (first_signal_relay);

endmodule
`default_nettype wire
